// ==== pkg/synth_ctrl_pkg.sv ====
// constants for the serial-programmed synthesizer control block
// assumes a single 20 MHz system clock; serial bus pins sampled synchronously
package synth_ctrl_pkg;
  localparam int WORD_W    = 24;
  localparam int ADDR_HI   = 23;   // top address bit
  localparam int ADDR_LO   = 22;   // second address bit
  localparam logic [1:0] ADDR_A = 2'h0;
  localparam logic [1:0] ADDR_B = 2'h1;
  localparam logic [1:0] ADDR_C = 2'h2;
  // a word fields
  localparam int A_FM      = 21;
  localparam int A_NF_HI   = 20;
  localparam int A_NF_LO   = 18;
  localparam int A_N_HI    = 17;
  localparam int A_N_LO    = 2;
  // b word fields
  localparam int B_PD_MAIN = 9;
  localparam int B_PD_AUX  = 8;
  localparam int B_FC_HI   = 7;
  localparam int B_FC_LO   = 0;
  // c word fields
  localparam int C_CP1     = 7;
  localparam int C_CP0     = 6;
  // defaults
  localparam logic [23:0] A_DEFAULT = 24'h0888c0;
  localparam logic [23:0] B_DEFAULT = 24'h451350;
  localparam logic [23:0] C_DEFAULT = 24'h81cac0;
  localparam logic [15:0] N_MIN     = 16'h0200;
  localparam logic [2:0]  MOD8_LAST = 3'h7;
  localparam logic [2:0]  MOD5_LAST = 3'h4;
  localparam logic [2:0]  MOD8_SPAN = 3'h0; // wrap arithmetic span helper
endpackage

// ==== hdl/frac_divider.sv ====
// fractional main divider: counts vco cycles and adds the increment per cycle
// assumes vco_tick is a one-cycle enable from the sampled prescaler domain
`timescale 1ns/100ps
module frac_divider
  import synth_ctrl_pkg::*;
(
  input  wire logic        clk,          // system clock
  input  wire logic        rst_n,        // synchronised reset
  input  wire logic        enable,       // divider powered
  input  wire logic        resync,       // restart count on power-up
  input  wire logic        vco_tick,     // one vco cycle
  input  wire logic [15:0] ratio,        // programmed ratio
  input  wire logic [2:0]  increment,    // fractional increment
  input  wire logic        mod5,         // modulus select
  output logic             cycle_end,    // divider output pulse
  output logic             carry_out     // this cycle stretched
);
  logic [16:0] cnt_reg, cnt_next;
  logic [3:0]  acc_reg, acc_next;
  logic        stretch_reg, stretch_next;
  logic        end_reg, end_next;
  logic [16:0] target;
  logic [3:0]  q;
  logic [3:0]  sum;

  // count ratio or ratio+1 cycles, add increment at each boundary
  always_comb
  begin
    q            = mod5 ? 4'h5 : 4'h8;
    target       = {1'b0, ratio} + {16'h0000, stretch_reg};
    sum          = acc_reg + {1'b0, increment};
    cnt_next     = cnt_reg;
    acc_next     = acc_reg;
    stretch_next = stretch_reg;
    end_next     = 1'b0;
    if (!enable || resync)
    begin
      cnt_next     = 17'h00001;
      acc_next     = 4'h0;
      stretch_next = 1'b0;
    end
    else if (vco_tick)
    begin
      if (cnt_reg >= target)
      begin
        cnt_next = 17'h00001;
        end_next = 1'b1;
        if (sum >= q)
        begin
          acc_next     = sum - q;
          stretch_next = 1'b1;
        end
        else
        begin
          acc_next     = sum;
          stretch_next = 1'b0;
        end
      end
      else
        cnt_next = cnt_reg + 17'h00001;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg     <= 17'h00001;
      acc_reg     <= 4'h0;
      stretch_reg <= 1'b0;
      end_reg     <= 1'b0;
    end
    else
    begin
      cnt_reg     <= cnt_next;
      acc_reg     <= acc_next;
      stretch_reg <= stretch_next;
      end_reg     <= end_next;
    end
  end

  assign cycle_end = end_reg;
  assign carry_out = stretch_reg;

  chk_acc_range: assert property (@(posedge clk) disable iff (!rst_n)
    acc_reg < q) else $error("accumulator beyond modulus");
endmodule

// ==== hdl/synth_serial_program_lock_ctrl.sv ====
// serial programming, word staging, lock and power logic of the synthesizer
// assumes serial pins already synchronous to clk; one system clock
// What this block does
// - program through clock, strobe, data lines
// - 24-bit words with two address bits
// - strobe high freezes the shift register
// - strobe decodes address, loads working or staging
// - dac bits staged until a word loads
// - main ratio 512 to 65535 only; any 16-bit value is applied unchecked
// - lock is and of both detectors
// - lock means phase error under one reference period
// - one loop down, lock follows the other
// - both loops down forces lock low
// - power is pin xor software bit
// - dividers resynchronise on leaving power-down
// - pump select disables integral, picks strength
// - speed-up gives five times proportional current
// - aux pump from aux detector, main from main
// - speed-up after a word while strobe high
// - accumulator overflow lengthens cycle by one
// - main power bit powers dividers and pumps
`timescale 1ns/100ps
module synth_serial_program_lock_ctrl
  import synth_ctrl_pkg::*;
(
  input  wire logic        clk,                        // 20 MHz system clock
  input  wire logic        rst_n,                      // async reset, active low
  input  wire logic        ser_clk,                    // serial shift clock, sampled
  input  wire logic        ser_strobe,                 // serial strobe, active high
  input  wire logic        ser_data,                   // serial data
  input  wire logic        hw_power_control_pin,       // hardware power pin
  input  wire logic        main_pd_up,                 // main detector pump up
  input  wire logic        main_pd_dn,                 // main detector pump down
  input  wire logic        aux_pd_up,                  // aux detector pump up
  input  wire logic        aux_pd_dn,                  // aux detector pump down
  input  wire logic        main_phase_ok,              // main phase error under 1 ref period
  input  wire logic        aux_phase_ok,               // aux phase error under 1 ref period
  input  wire logic        vco_tick,                   // one vco cycle enable
  output logic             lock_out,                   // combined lock
  output logic             main_powered,               // main loop powered
  output logic             aux_powered,                // aux loop powered
  output logic             main_proportional_pump_out, // proportional pump active
  output logic             main_integral_pump_out,     // integral pump active
  output logic             aux_pump_out,               // aux pump active
  output logic             pump_dir_up,                // main pump direction
  output logic             integral_pump_disable_bit,  // integral pump disabled
  output logic             pump_current_level_bit,     // reduced current set
  output logic             speedup_pump_current,       // speed-up 5x current active
  output logic [7:0]       comp_dac_setting,           // applied compensation dac
  output logic [15:0]      main_ratio,                 // applied main ratio
  output logic             main_cycle_end              // main divider output
);
  logic [1:0] rst_sync_reg;
  logic       srst_n;

  // release reset through two flops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign srst_n = rst_sync_reg[1];

  logic [23:0] shift_reg, shift_next;
  logic [23:0] a_word_reg, a_word_next;  // main_fractional_divider_word
  logic [23:0] b_word_reg, b_word_next;
  logic [23:0] c_word_reg, c_word_next;
  logic [7:0]  dac_stage_reg, dac_stage_next;
  logic [7:0]  dac_reg, dac_next;
  logic [15:0] ratio_reg, ratio_next;
  logic        ratio_pend_reg, ratio_pend_next;
  logic        sclk_d_reg, strobe_d_reg;
  logic        speedup_reg, speedup_next;
  logic        a_armed_reg, a_armed_next;
  logic        sclk_rise, strobe_rise;
  logic [1:0]  addr;
  logic        div_cycle_end;

  assign sclk_rise   = ser_clk & ~sclk_d_reg;
  assign strobe_rise = ser_strobe & ~strobe_d_reg;
  assign addr        = {shift_reg[ADDR_HI], shift_reg[ADDR_LO]};

  // shifting, word decode, staging and speed-up
  always_comb
  begin
    shift_next      = shift_reg;
    a_word_next     = a_word_reg;
    b_word_next     = b_word_reg;
    c_word_next     = c_word_reg;
    dac_stage_next  = dac_stage_reg;
    dac_next        = dac_reg;
    ratio_next      = ratio_reg;
    ratio_pend_next = ratio_pend_reg;
    a_armed_next    = a_armed_reg;
    speedup_next    = speedup_reg;
    // ratio swaps only at a divider boundary to keep phase clean, or at once while main is down;
    // placed first so a new a word latched in the same cycle stays pending
    if (ratio_pend_reg && (div_cycle_end || !main_powered))
    begin
      ratio_next      = a_word_reg[A_N_HI:A_N_LO];
      ratio_pend_next = 1'b0;
    end
    // clock ignored while strobe high, protecting the latched word
    if (sclk_rise && !ser_strobe)
      shift_next = {ser_data, shift_reg[23:1]};
    if (strobe_rise)
    begin
      case (addr)
        ADDR_A:
        begin
          a_word_next     = shift_reg;
          dac_next        = dac_stage_reg;
          ratio_pend_next = 1'b1;
          a_armed_next    = 1'b1;
        end
        ADDR_B:
        begin
          b_word_next    = shift_reg;
          dac_stage_next = shift_reg[B_FC_HI:B_FC_LO];
        end
        ADDR_C:  c_word_next = shift_reg;
        default: ;                                     // test word not used
      endcase
    end
    // speed-up only from a word set until strobe falls
    speedup_next = ser_strobe && (a_armed_reg || (strobe_rise && addr == ADDR_A));
    if (!ser_strobe)
      a_armed_next = 1'b0;
  end

  always_ff @(posedge clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      shift_reg      <= 24'h000000;
      a_word_reg     <= A_DEFAULT;
      b_word_reg     <= B_DEFAULT;
      c_word_reg     <= C_DEFAULT;
      dac_stage_reg  <= B_DEFAULT[B_FC_HI:B_FC_LO];
      dac_reg        <= B_DEFAULT[B_FC_HI:B_FC_LO];
      ratio_reg      <= A_DEFAULT[A_N_HI:A_N_LO];
      ratio_pend_reg <= 1'b0;
      sclk_d_reg     <= 1'b0;
      strobe_d_reg   <= 1'b0;
      speedup_reg    <= 1'b0;
      a_armed_reg    <= 1'b0;
    end
    else
    begin
      shift_reg      <= shift_next;
      a_word_reg     <= a_word_next;
      b_word_reg     <= b_word_next;
      c_word_reg     <= c_word_next;
      dac_stage_reg  <= dac_stage_next;
      dac_reg        <= dac_next;
      ratio_reg      <= ratio_next;
      ratio_pend_reg <= ratio_pend_next;
      sclk_d_reg     <= ser_clk;
      strobe_d_reg   <= ser_strobe;
      speedup_reg    <= speedup_next;
      a_armed_reg    <= a_armed_next;
    end
  end

  logic main_pwr_next, aux_pwr_next, main_pwr_reg, aux_pwr_reg;
  logic lock_next, lock_reg;
  logic php_next, phi_next, pha_next, dir_next;
  logic php_reg, phi_reg, pha_reg, dir_reg;
  logic resync;

  // power, lock and pump steering
  always_comb
  begin
    main_pwr_next = hw_power_control_pin ^ b_word_reg[B_PD_MAIN];
    aux_pwr_next  = hw_power_control_pin ^ b_word_reg[B_PD_AUX];
    if (main_pwr_reg && aux_pwr_reg)
      lock_next = main_phase_ok & aux_phase_ok;
    else if (main_pwr_reg)
      lock_next = main_phase_ok;
    else if (aux_pwr_reg)
      lock_next = aux_phase_ok;
    else
      lock_next = 1'b0;
    php_next = main_pwr_reg & (main_pd_up | main_pd_dn);
    phi_next = php_next & ~c_word_reg[C_CP1];
    pha_next = aux_pwr_reg & (aux_pd_up | aux_pd_dn);
    dir_next = main_pd_up;
  end

  always_ff @(posedge clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      main_pwr_reg <= 1'b0;
      aux_pwr_reg  <= 1'b0;
      lock_reg     <= 1'b0;
      php_reg      <= 1'b0;
      phi_reg      <= 1'b0;
      pha_reg      <= 1'b0;
      dir_reg      <= 1'b0;
    end
    else
    begin
      main_pwr_reg <= main_pwr_next;
      aux_pwr_reg  <= aux_pwr_next;
      lock_reg     <= lock_next;
      php_reg      <= php_next;
      phi_reg      <= phi_next;
      pha_reg      <= pha_next;
      dir_reg      <= dir_next;
    end
  end

  assign resync = main_pwr_next & ~main_pwr_reg;

  frac_divider u_div (
    .clk       (clk),
    .rst_n     (srst_n),
    .enable    (main_pwr_reg),
    .resync    (resync),
    .vco_tick  (vco_tick),
    .ratio     (ratio_reg),
    .increment (a_word_reg[A_NF_HI:A_NF_LO]),
    .mod5      (a_word_reg[A_FM]),
    .cycle_end (div_cycle_end),
    .carry_out ()
  );

  assign lock_out                   = lock_reg;
  assign main_powered               = main_pwr_reg;
  assign aux_powered                = aux_pwr_reg;
  assign main_proportional_pump_out = php_reg;
  assign main_integral_pump_out     = phi_reg;
  assign aux_pump_out               = pha_reg;
  assign pump_dir_up                = dir_reg;
  assign integral_pump_disable_bit  = c_word_reg[C_CP1];
  assign pump_current_level_bit     = c_word_reg[C_CP0];
  assign speedup_pump_current       = speedup_reg;
  assign comp_dac_setting           = dac_reg;
  assign main_ratio                 = ratio_reg;
  assign main_cycle_end             = div_cycle_end;

  chk_freeze_shift: assert property (@(posedge clk) disable iff (!srst_n)
    ser_strobe && $past(ser_strobe) |=> $stable(shift_reg))
    else $error("shift moved under strobe");
  chk_dac_staged: assert property (@(posedge clk) disable iff (!srst_n)
    strobe_rise && addr == ADDR_B |=> $stable(dac_reg))
    else $error("dac applied without a word");
  chk_dac_apply: assert property (@(posedge clk) disable iff (!srst_n)
    strobe_rise && addr == ADDR_A |=> dac_reg == $past(dac_stage_reg))
    else $error("dac not applied with a word");
  chk_lock_both_down: assert property (@(posedge clk) disable iff (!srst_n)
    !main_pwr_reg && !aux_pwr_reg |=> !lock_reg)
    else $error("lock high with both down");
  chk_lock_and: assert property (@(posedge clk) disable iff (!srst_n)
    main_pwr_reg && aux_pwr_reg && !main_phase_ok |=> !lock_reg)
    else $error("lock without main detector");
  chk_power_xor: assert property (@(posedge clk) disable iff (!srst_n)
    1'b1 |=> main_pwr_reg == ($past(hw_power_control_pin) ^ $past(b_word_reg[B_PD_MAIN])))
    else $error("main power not pin xor bit");
  chk_speedup_end: assert property (@(posedge clk) disable iff (!srst_n)
    !ser_strobe |=> !speedup_reg)
    else $error("speed-up past strobe low");
  chk_integral_off: assert property (@(posedge clk) disable iff (!srst_n)
    c_word_reg[C_CP1] && $past(c_word_reg[C_CP1]) |-> !phi_reg)
    else $error("integral pump with disable set");
  chk_ratio_boundary: assert property (@(posedge clk) disable iff (!srst_n)
    main_pwr_reg && $past(main_pwr_reg) && $changed(ratio_reg) |-> $past(div_cycle_end))
    else $error("ratio changed mid cycle");

  cov_a_word: cover property (@(posedge clk) strobe_rise && addr == ADDR_A);
  cov_b_word: cover property (@(posedge clk) strobe_rise && addr == ADDR_B);
  cov_speedup: cover property (@(posedge clk) speedup_reg);
  cov_locked: cover property (@(posedge clk) lock_reg && main_pwr_reg && aux_pwr_reg);
endmodule

// ==== verification/serial_host_model.sv ====
// host side of the three-wire programming bus
// assumes clk is the system clock; pins move just after its rising edge
`timescale 1ns/100ps
module serial_host_model
#(
  parameter int GAP = 20  // strobe low time in clk cycles, one comparison period
)
(
  input  wire logic clk,        // system clock
  output logic      ser_clk,    // shift clock, still outside frames
  output logic      ser_strobe, // latch strobe, active high
  output logic      ser_data    // serial data
);
  // bus idles with clock and strobe low
  initial
  begin
    ser_clk = 1'b0;
    ser_strobe = 1'b0;
    ser_data = 1'b0;
  end

  // data leads the rising edge by two cycles; clock high three cycles, low five
  task automatic pulse_bit(input logic d);
    @(posedge clk);
    ser_data <= d;
    repeat (2) @(posedge clk);
    ser_clk <= 1'b1;
    repeat (3) @(posedge clk);
    ser_clk <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // whole words only, first bit in lands at position zero
  task automatic shift_word(input logic [23:0] w);
    for (int i = 0; i < 24; i++)
      pulse_bit(w[i]);
    @(posedge clk);
    ser_data <= ~w[23]; // idle data never repeats the last bit
  endtask

  // strobe pulse; nj clock edges of junk while high probe the freeze
  task automatic latch(input int hold, input logic [23:0] junk, input int nj);
    @(posedge clk);
    ser_strobe <= 1'b1;
    for (int i = 0; i < nj; i++)
      pulse_bit(junk[i]);
    repeat (hold) @(posedge clk);
    ser_strobe <= 1'b0;
    repeat (GAP) @(posedge clk);
  endtask
endmodule

// ==== verification/testbench.sv ====
// self-checking bench for serial programming, staging, lock and power logic
// assumes the host model drives the serial pins; one 20 MHz clock
`timescale 1ns/100ps
module testbench
  import synth_ctrl_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ser_clk, ser_strobe, ser_data;
  logic        hw_power_control_pin = 1'b0;
  logic        main_pd_up = 1'b0, main_pd_dn = 1'b0, aux_pd_up = 1'b0, aux_pd_dn = 1'b0;
  logic        main_phase_ok = 1'b0, aux_phase_ok = 1'b0, vco_tick = 1'b0;
  logic        lock_out, main_powered, aux_powered, integral_pump_disable_bit;
  logic        pump_current_level_bit, speedup_pump_current;
  logic [7:0]  comp_dac_setting;
  logic        php_o, phi_o, pha_o, dir_o, end_o;
  logic [3:0]  pd_seen = 4'h0;
  int          ticks = 0;
  logic        end_seen = 1'b0;
  logic [15:0] main_ratio;
  integer      seed = 32'h48f5bb25;
  int          err_total = 0, total_checks = 0, cycles = 0;
  logic        mon_on = 1'b0, vco_en = 1'b0, pin_v = 1'b0, mok_v = 1'b0, aok_v = 1'b0;
  logic        sw_main, sw_aux, e_spd = 1'b0, e_idb, e_lvl;
  logic [7:0]  e_dac;
  logic [15:0] e_ratio;
  logic [29:0] last_note;
  logic [29:0] exp_q[$];
  wire  [29:0] obs = {lock_out, speedup_pump_current, main_powered, aux_powered,
                      integral_pump_disable_bit, pump_current_level_bit, comp_dac_setting,
                      main_ratio};

  serial_host_model #(.GAP(20)) serial_host_model_inst (.clk(clk), .ser_clk(ser_clk),
    .ser_strobe(ser_strobe), .ser_data(ser_data));

  synth_serial_program_lock_ctrl synth_serial_program_lock_ctrl_inst (.clk(clk),
    .rst_n(rst_n), .ser_clk(ser_clk), .ser_strobe(ser_strobe), .ser_data(ser_data),
    .hw_power_control_pin(hw_power_control_pin), .main_pd_up(main_pd_up),
    .main_pd_dn(main_pd_dn), .aux_pd_up(aux_pd_up), .aux_pd_dn(aux_pd_dn),
    .main_phase_ok(main_phase_ok), .aux_phase_ok(aux_phase_ok), .vco_tick(vco_tick),
    .lock_out(lock_out), .main_powered(main_powered), .aux_powered(aux_powered),
    .main_proportional_pump_out(php_o), .main_integral_pump_out(phi_o),
    .aux_pump_out(pha_o), .pump_dir_up(dir_o),
    .integral_pump_disable_bit(integral_pump_disable_bit),
    .pump_current_level_bit(pump_current_level_bit),
    .speedup_pump_current(speedup_pump_current), .comp_dac_setting(comp_dac_setting),
    .main_ratio(main_ratio), .main_cycle_end(end_o));

  // 50 ns period
  initial
  begin
    forever #25 clk = ~clk;
  end

  // detector pulses and vco ticks; vco held off while a reload must wait
  // pd_seen and ticks hold what the design samples at this same edge
  always @(posedge clk)
  begin
    pd_seen <= {main_pd_up, main_pd_dn, aux_pd_up, aux_pd_dn};
    ticks <= ticks + (vco_tick ? 1 : 0);
    main_pd_up <= 1'($random(seed));
    main_pd_dn <= 1'($random(seed));
    aux_pd_up <= 1'($random(seed));
    aux_pd_dn <= 1'($random(seed));
    vco_tick <= vco_en & 1'($random(seed));
  end

  task automatic check(input logic [29:0] seen, input logic [29:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // hang guard, generous against roughly five thousand cycles of work
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      err_total++;
      test_done();
    end
  end

  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, err_total);
  endtask

  // expected outputs from the programmed state and the pins
  function automatic logic [29:0] vec();
    logic mp;
    logic ap;
    mp = sw_main ^ pin_v;
    ap = sw_aux ^ pin_v;
    return {(mp | ap) & (~mp | mok_v) & (~ap | aok_v),
            e_spd, mp, ap, e_idb, e_lvl, e_dac, e_ratio};
  endfunction

  // only a real change is noted, the monitor pops one per change
  task automatic note();
    if (vec() !== last_note)
    begin
      last_note = vec();
      exp_q.push_back(last_note);
    end
  endtask

  // pump flags expected from the detector levels sampled at the last edge
  function automatic logic [3:0] pump_exp();
    logic mp;
    logic ap;
    mp = sw_main ^ pin_v;
    ap = sw_aux ^ pin_v;
    return {mp & (pd_seen[3] | pd_seen[2]), mp & (pd_seen[3] | pd_seen[2]) & ~e_idb,
            ap & (pd_seen[1] | pd_seen[0]), pd_seen[3]};
  endfunction

  task automatic settle();
    while (exp_q.size() != 0)
      @(posedge clk);
    repeat (8) @(posedge clk);
    @(negedge clk);
    check({26'h0, php_o, phi_o, pha_o, dir_o}, {26'h0, pump_exp()});
  endtask

  // first divider output only after exactly the applied ratio of ticks
  always @(negedge clk)
  begin
    if (end_o && !end_seen)
    begin
      end_seen = 1'b1;
      check(30'(ticks), 30'(N_MIN));
    end
  end

  task automatic send(input logic [23:0] w, input int hold);
    serial_host_model_inst.shift_word(w);
    serial_host_model_inst.latch(hold, 24'h0, 0);
    settle();
  endtask

  task automatic set_in(input logic p, input logic mo, input logic ao);
    @(posedge clk);
    pin_v = p;
    mok_v = mo;
    aok_v = ao;
    hw_power_control_pin <= p;
    main_phase_ok <= mo;
    aux_phase_ok <= ao;
    note();
    settle();
  endtask

  function automatic logic [23:0] b_word(input logic [7:0] fc);
    logic [23:0] w;
    w = B_DEFAULT;
    w[B_PD_MAIN] = sw_main;
    w[B_PD_AUX] = sw_aux;
    w[B_FC_HI:B_FC_LO] = fc;
    return w;
  endfunction

  // strobe held ten cycles so speed-up is seen rising and falling
  task automatic load_a(input logic [15:0] r, input logic [7:0] fc, input logic now);
    e_dac = fc;
    e_spd = 1'b1;
    if (now)
      e_ratio = r;
    note();
    e_spd = 1'b0;
    note();
    send({ADDR_A, 1'($random(seed)), 3'($random(seed)), r, 2'($random(seed))}, 10);
  endtask

  // monitor: waits out multi-cycle updates before comparing
  initial
  begin
    logic [29:0] prev;
    wait (mon_on);
    prev = obs;
    forever
    begin
      @(negedge clk);
      if (obs !== prev)
      begin
        repeat (4) @(negedge clk);
        if (exp_q.size() == 0)
          check(obs, prev);
        else
          check(obs, exp_q.pop_front());
        prev = obs;
      end
    end
  end

  initial
  begin
    logic [23:0] w;
    logic [7:0]  fc;
    e_dac = B_DEFAULT[B_FC_HI:B_FC_LO];
    e_ratio = A_DEFAULT[A_N_HI:A_N_LO];
    e_idb = C_DEFAULT[C_CP1];
    e_lvl = C_DEFAULT[C_CP0];
    sw_main = B_DEFAULT[B_PD_MAIN];
    sw_aux = B_DEFAULT[B_PD_AUX];
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    last_note = vec();
    check(obs, last_note);
    mon_on = 1'b1;
    // c words first, every pump select code
    for (int cp = 0; cp < 4; cp++)
    begin
      w = {ADDR_C, 22'($random(seed))};
      w[C_CP1] = cp[1];
      w[C_CP0] = cp[0];
      e_idb = cp[1];
      e_lvl = cp[0];
      note();
      send(w, 4);
    end
    end_test("pump select");
    fc = 8'($random(seed));
    sw_main = 1'b0;
    note();
    send(b_word(fc), 4);
    load_a(N_MIN, fc, 1'b1);
    end_test("staging");
    for (int k = 0; k < 16; k++)
    begin
      if (k[1:0] == 2'h0)
      begin
        sw_main = k[3];
        sw_aux = k[2];
        note();
        send(b_word(fc), 4);
      end
      set_in(1'b0, k[1], k[0]);
    end
    end_test("lock");
    set_in(1'b1, 1'b1, 1'b1);
    set_in(1'b0, 1'b1, 1'b1);
    end_test("power pin");
    // main powered and no vco ticks: the new ratio must wait
    fc = 8'($random(seed));
    send(b_word(fc), 4);
    load_a(16'hffff, fc, 1'b0);
    e_ratio = 16'hffff;
    note();
    vco_en = 1'b1;
    settle();
    end_test("reload");
    w = {ADDR_C, 22'($random(seed))};
    w[C_CP1] = 1'b0;
    w[C_CP0] = 1'b0;
    e_idb = 1'b0;
    e_lvl = 1'b0;
    note();
    serial_host_model_inst.shift_word(w);
    serial_host_model_inst.latch(4, w | 24'h0000c0, 24);
    serial_host_model_inst.latch(4, 24'h0, 0);
    send(24'hffffff, 4);
    check(obs, last_note);
    end_test("refusals");
    test_done();
  end
endmodule
